// ### lpmra_pkg.sv
// Functional notes
// R1 - Controller sends only NOPs while a register read is running.
// R2 - Register read data sits on low byte, first beat; rest is filler.
// R3 - Controller spaces register read to WRITE by RL+RU(tDQSCK)+2+1+WL.
// R4 - Controller spaces register read to register write by RL+RU(tDQSCK)+2+1.
// R5 - Register read never truncates bursts; waits BL/2 after a READ.
// R6 - After WRITE, controller waits WL+1+BL/2+RU(tWTR) before register read.
// R7 - Truncated bursts use their effective length as BL in spacing.
// R8 - Temperature status refreshed from sensor at most 32 ms apart.
// R9 - After low-power exit the temperature status is no older than interval.
// R10 - Controller polls temperature fast enough to stay within 2 C margin.
// R11 - Pattern A returns 1,0,1,0; pattern B returns 0,0,1,1.
// R12 - Pattern reads drive every line of each lane like its lowest bit.
// R13 - Controller issues pattern reads only while the device is idle.
// R14 - Register write: CS low, CA3..CA0 low; address and data from both edges. Code takes data from the falling edge only.
// R15 - Writes to read-only registers are ignored.
// R16 - Register writes only with all banks idle; reads allowed with banks active.
// R17 - Controller sends only NOPs while a register write is running.
// R18 - Reset write restores defaults, leaves array undefined, needs NOP wait.
// R19 - Four impedance calibration commands: init, long, short, reset.
// R20 - Controller issues calibration only when idle with banks precharged.
// R21 - Data bus stays quiet during init, long and short calibration.
// R22 - Shared resistor: controller keeps calibrations from overlapping.
// R23 - Calibration ball tied to supply: calibration commands are ignored.
// R24 - Register read: CS low, CA2..CA0 low, CA3 high; address from both edges.
// R25 - Register read is a four-beat burst toggling every strobe.
// R26 - Eight address bits from both edges form one register index.
`default_nettype none
package lpmra_pkg;
  localparam int CA_W = 10;
  localparam int MR_ADDR_W = 8;
  localparam int MR_DATA_W = 8;
  localparam int OPCODE_W = 4;
  localparam int ADDR_RISE_LSB = 4;
  localparam int ADDR_FALL_W = 2;
  localparam int DATA_FALL_LSB = 2;
  localparam int BYTE_W = 8;
  localparam int TEMP_W = 3;
  localparam int BURST_BEATS = 4;
  localparam int BEAT_W = 2;
  localparam int CNT_W = 16;
  localparam logic [OPCODE_W-1:0] MRR_OPCODE = 4'h8;
  localparam logic [OPCODE_W-1:0] MRW_OPCODE = 4'h0;
  localparam logic [MR_ADDR_W-1:0] TEMP_STATUS_ADDR = 8'h04;
  localparam logic [MR_ADDR_W-1:0] IMPEDANCE_CAL_ADDR = 8'h0a;
  localparam logic [MR_ADDR_W-1:0] CALIB_PATTERN_A_ADDR = 8'h20;
  localparam logic [MR_ADDR_W-1:0] CALIB_PATTERN_B_ADDR = 8'h28;
  localparam logic [MR_ADDR_W-1:0] RESET_ADDR = 8'h3f;
  localparam logic [MR_ADDR_W-1:0] CFG_BASE_ADDR = 8'h01;
  localparam logic [MR_DATA_W-1:0] CFG_DEFAULT = 8'h00;
  localparam logic [BURST_BEATS-1:0] PATTERN_A_BITS = 4'h5;
  localparam logic [BURST_BEATS-1:0] PATTERN_B_BITS = 4'hc;
  localparam logic [MR_DATA_W-1:0] CAL_INIT_CODE = 8'h01;
  localparam logic [MR_DATA_W-1:0] CAL_LONG_CODE = 8'h02;
  localparam logic [MR_DATA_W-1:0] CAL_SHORT_CODE = 8'h03;
  localparam logic [MR_DATA_W-1:0] CAL_RESET_CODE = 8'h04;
  localparam int CLK_HZ = 10_000_000;
  localparam int SENSOR_UPDATE_MS = 32;
  localparam int SENSOR_UPDATE_CYCLES = SENSOR_UPDATE_MS * (CLK_HZ / 1000);
  localparam int READ_LAT_DEF = 6;
  localparam int MRW_CYCLES_DEF = 5;
  localparam int AUTO_INIT_CYCLES_DEF = 8;
  localparam int CAL_INIT_CYCLES_DEF = 64;
  localparam int CAL_LONG_CYCLES_DEF = 32;
  localparam int CAL_SHORT_CYCLES_DEF = 8;
  localparam int CAL_RESET_CYCLES_DEF = 1;
  typedef enum logic [2:0] {ST_IDLE, ST_MRR, ST_MRW, ST_CAL, ST_INIT} lpmra_state_type;
  typedef enum logic [1:0] {CAL_INIT, CAL_LONG, CAL_SHORT, CAL_RESET} lpmra_cal_type;
endpackage
`default_nettype wire

// ### lpmra_sensor_timer.sv
`timescale 1ns/100ps
`default_nettype none
module lpmra_sensor_timer #(
  parameter int CYCLES = 320000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic restart,
  output logic tick
);
  import lpmra_pkg::*;
  localparam int TW = $clog2(CYCLES + 1);
  localparam logic [TW-1:0] LAST = TW'(CYCLES - 1);
  logic [TW-1:0] cnt_ff;
  logic tick_ff;
  // Periodic load strobe, restarted on low-power exit
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      tick_ff <= restart || (cnt_ff == LAST); // R8 R9
      if (restart || (cnt_ff == LAST))
        cnt_ff <= '0;
      else
        cnt_ff <= cnt_ff + 1'b1;
    end
  end
  assign tick = tick_ff;
endmodule // lpmra_sensor_timer
`default_nettype wire

// ### lpmra_mode_reg.sv
`timescale 1ns/100ps
`default_nettype none
module lpmra_mode_reg #(
  parameter int DQ_W = 16,
  parameter int NUM_CFG = 3,
  parameter int READ_LAT = lpmra_pkg::READ_LAT_DEF,
  parameter int MRW_CYCLES = lpmra_pkg::MRW_CYCLES_DEF,
  parameter int AUTO_INIT_CYCLES = lpmra_pkg::AUTO_INIT_CYCLES_DEF,
  parameter int CAL_INIT_CYCLES = lpmra_pkg::CAL_INIT_CYCLES_DEF,
  parameter int CAL_LONG_CYCLES = lpmra_pkg::CAL_LONG_CYCLES_DEF,
  parameter int CAL_SHORT_CYCLES = lpmra_pkg::CAL_SHORT_CYCLES_DEF,
  parameter int CAL_RESET_CYCLES = lpmra_pkg::CAL_RESET_CYCLES_DEF,
  parameter int SENSOR_CYCLES = lpmra_pkg::SENSOR_UPDATE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic csN,
  input wire logic [lpmra_pkg::CA_W-1:0] caRise,
  input wire logic [lpmra_pkg::CA_W-1:0] caFall,
  input wire logic zqTiedSupply,
  input wire logic [lpmra_pkg::TEMP_W-1:0] sensorTemp,
  input wire logic lowPowerExit,
  output logic [DQ_W-1:0] dqOut,
  output logic dqOe,
  output logic [DQ_W/8-1:0] dqsOut,
  output logic cmdBusy,
  output logic calBusy,
  output logic autoInitBusy,
  output logic arrayUndefined,
  output logic impAccuracy,
  output logic [lpmra_pkg::TEMP_W-1:0] tempStatus,
  output logic [NUM_CFG*8-1:0] cfgRegs
);
  import lpmra_pkg::*;
  localparam int LANES = DQ_W / BYTE_W;
  localparam int CFG_IDX_W = $clog2(NUM_CFG);
  localparam int OE_DELAY = READ_LAT + 1;
  localparam logic [MR_ADDR_W-1:0] NUM_CFG_A = MR_ADDR_W'(NUM_CFG);
  localparam logic [CNT_W-1:0] BURST_FIRST = CNT_W'(READ_LAT - 1);
  localparam logic [CNT_W-1:0] BURST_LAST = CNT_W'(READ_LAT + BURST_BEATS - 1);

  lpmra_state_type state_ff, nxt_state;
  lpmra_cal_type calKind_ff, calKind;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt, calLen_ff, calLen;
  logic [MR_ADDR_W-1:0] mrAddr, cfgOff;
  logic [MR_DATA_W-1:0] mrData, readVal, rdVal_ff;
  logic [MR_DATA_W-1:0] cfg_ff [NUM_CFG];
  logic [CFG_IDX_W-1:0] cfgIdx;
  logic [BURST_BEATS-1:0] patBits_ff;
  logic [BEAT_W-1:0] beatIdx;
  logic [DQ_W-1:0] dqOut_ff;
  logic [TEMP_W-1:0] tempStatus_ff;
  logic [31:0] sinceLoad_ff;
  logic isMrr, isMrw, mrrGo, mrwGo, cfgHit, patA, patB, calHit, calValid, calGo;
  logic resetGo, burstOn, patSel_ff, dqOe_ff, dqs_ff, sensorTick, calDone;
  logic cmdBusy_ff, calBusy_ff, autoInitBusy_ff, arrayUndefined_ff, impAccuracy_ff;

  // Command decode on the rising-edge and falling-edge halves of the bus
  assign isMrr = !csN && (caRise[OPCODE_W-1:0] == MRR_OPCODE); // R24
  assign isMrw = !csN && (caRise[OPCODE_W-1:0] == MRW_OPCODE); // R14
  assign mrAddr = {caRise[CA_W-1:ADDR_RISE_LSB], caFall[ADDR_FALL_W-1:0]}; // R26
  assign mrData = caFall[CA_W-1:DATA_FALL_LSB]; // R14
  assign mrrGo = clkEn && (state_ff == ST_IDLE) && isMrr; // R1
  assign mrwGo = clkEn && (state_ff == ST_IDLE) && isMrw; // R17
  assign cfgOff = mrAddr - CFG_BASE_ADDR;
  assign cfgHit = (mrAddr >= CFG_BASE_ADDR) && (cfgOff < NUM_CFG_A); // R15
  assign cfgIdx = cfgOff[CFG_IDX_W-1:0];
  assign patA = (mrAddr == CALIB_PATTERN_A_ADDR);
  assign patB = (mrAddr == CALIB_PATTERN_B_ADDR);
  assign resetGo = mrwGo && (mrAddr == RESET_ADDR);
  assign calHit = (mrAddr == IMPEDANCE_CAL_ADDR);
  assign calGo = mrwGo && calHit && calValid && !zqTiedSupply; // R23

  // Register index to read value
  always_comb
  begin
    readVal = '0;
    if (mrAddr == TEMP_STATUS_ADDR)
      readVal = {{(MR_DATA_W-TEMP_W){1'b0}}, tempStatus_ff};
    else if (cfgHit)
      readVal = cfg_ff[cfgIdx]; // R26
  end

  // Calibration code to kind and length
  always_comb
  begin
    calValid = 1'b1;
    calKind = CAL_INIT;
    calLen = CNT_W'(CAL_INIT_CYCLES);
    case (mrData)
      CAL_INIT_CODE: calKind = CAL_INIT;
      CAL_LONG_CODE:
      begin
        calKind = CAL_LONG;
        calLen = CNT_W'(CAL_LONG_CYCLES);
      end
      CAL_SHORT_CODE:
      begin
        calKind = CAL_SHORT;
        calLen = CNT_W'(CAL_SHORT_CYCLES);
      end
      CAL_RESET_CODE:
      begin
        calKind = CAL_RESET;
        calLen = CNT_W'(CAL_RESET_CYCLES);
      end
      default: calValid = 1'b0;
    endcase
  end

  // Command sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 1'b1;
    calDone = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_cnt = '0;
        if (isMrr)
          nxt_state = ST_MRR;
        else if (isMrw && (mrAddr == RESET_ADDR))
          nxt_state = ST_INIT; // R18
        else if (isMrw && calHit && calValid && !zqTiedSupply)
          nxt_state = ST_CAL; // R19
        else if (isMrw)
          nxt_state = ST_MRW;
      end
      ST_MRR:
        if (cnt_ff == BURST_LAST)
          nxt_state = ST_IDLE;
      ST_MRW:
        if (cnt_ff == CNT_W'(MRW_CYCLES - 1))
          nxt_state = ST_IDLE;
      ST_CAL:
        if (cnt_ff == calLen_ff - 1'b1)
        begin
          nxt_state = ST_IDLE;
          calDone = 1'b1;
        end
      ST_INIT:
        if (cnt_ff == CNT_W'(AUTO_INIT_CYCLES - 1))
          nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      cmdBusy_ff <= 1'b0;
      calBusy_ff <= 1'b0;
      autoInitBusy_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cmdBusy_ff <= (nxt_state != ST_IDLE);
      calBusy_ff <= (nxt_state == ST_CAL);
      autoInitBusy_ff <= (nxt_state == ST_INIT); // R18
    end
  end

  // Read burst on the data lanes
  assign burstOn = (state_ff == ST_MRR) && (cnt_ff >= BURST_FIRST) && (cnt_ff < BURST_LAST);
  assign beatIdx = BEAT_W'(cnt_ff - BURST_FIRST);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdVal_ff <= '0;
      patSel_ff <= 1'b0;
      patBits_ff <= '0;
      dqOut_ff <= '0;
      dqOe_ff <= 1'b0;
      dqs_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      if (mrrGo)
      begin
        rdVal_ff <= readVal;
        patSel_ff <= patA || patB;
        patBits_ff <= patA ? PATTERN_A_BITS : PATTERN_B_BITS; // R11
      end
      dqOe_ff <= burstOn; // R25
      dqs_ff <= burstOn ? !dqs_ff : 1'b0; // R25
      if (!burstOn)
        dqOut_ff <= '0;
      else if (patSel_ff)
        dqOut_ff <= {DQ_W{patBits_ff[beatIdx]}}; // R11 R12
      else if (beatIdx == '0)
        dqOut_ff <= {{(DQ_W-BYTE_W){1'b0}}, rdVal_ff}; // R2
      else
        dqOut_ff <= '0; // R2
    end
  end

  // Writable configuration registers
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CFG; gi++)
    begin : g_cfg
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          cfg_ff[gi] <= CFG_DEFAULT;
        else if (clkEn)
        begin
          if (resetGo)
            cfg_ff[gi] <= CFG_DEFAULT; // R18
          else if (mrwGo && cfgHit && (cfgIdx == CFG_IDX_W'(gi)))
            cfg_ff[gi] <= mrData; // R14 R15
        end
      end
      assign cfgRegs[gi*BYTE_W +: BYTE_W] = cfg_ff[gi];
    end
  endgenerate

  // Impedance calibration state and array status
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      calKind_ff <= CAL_INIT;
      calLen_ff <= '0;
      impAccuracy_ff <= 1'b0;
      arrayUndefined_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      if (resetGo)
        arrayUndefined_ff <= 1'b1; // R18
      if (calGo)
      begin
        calKind_ff <= calKind;
        calLen_ff <= calLen;
        if (calKind == CAL_RESET)
          impAccuracy_ff <= 1'b0; // R19
      end
      else if (calDone && (calKind_ff == CAL_INIT || calKind_ff == CAL_LONG))
        impAccuracy_ff <= 1'b1; // R19
    end
  end

  // Temperature status refresh
  lpmra_sensor_timer #(
    .CYCLES(SENSOR_CYCLES)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .restart(lowPowerExit),
    .tick(sensorTick)
  );
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tempStatus_ff <= '0;
      sinceLoad_ff <= '0;
    end
    else if (clkEn)
    begin
      if (sensorTick)
        tempStatus_ff <= sensorTemp; // R8 R9
      sinceLoad_ff <= sensorTick ? 32'h0 : sinceLoad_ff + 32'h1;
    end
  end

  assign dqOut = dqOut_ff;
  assign dqOe = dqOe_ff;
  assign dqsOut = {LANES{dqs_ff}};
  assign cmdBusy = cmdBusy_ff;
  assign calBusy = calBusy_ff;
  assign autoInitBusy = autoInitBusy_ff;
  assign arrayUndefined = arrayUndefined_ff;
  assign impAccuracy = impAccuracy_ff;
  assign tempStatus = tempStatus_ff;

  a_first_beat_data: assert property ( // R2
    @(posedge ref_clk) disable iff (!rst_n || !clkEn)
    $rose(dqOe_ff) && !patSel_ff |-> dqOut_ff == {{(DQ_W-BYTE_W){1'b0}}, rdVal_ff}
  ) else $error("first beat does not carry register value");
  a_burst_four_beats: assert property ( // R25
    @(posedge ref_clk) disable iff (!rst_n || !clkEn)
    $rose(dqOe_ff) |-> dqOe_ff [*4] ##1 !dqOe_ff
  ) else $error("read burst is not four beats");
  a_read_latency: assert property ( // R24
    @(posedge ref_clk) disable iff (!rst_n || !clkEn)
    mrrGo |-> !dqOe_ff ##OE_DELAY $rose(dqOe_ff)
  ) else $error("read data not at read latency");
  a_strobe_toggle: assert property ( // R25
    @(posedge ref_clk) disable iff (!rst_n || !clkEn)
    dqOe_ff && $past(dqOe_ff) |-> dqs_ff != $past(dqs_ff)
  ) else $error("strobe did not toggle");
  a_pattern_lanes: assert property ( // R12
    @(posedge ref_clk) disable iff (!rst_n || !clkEn)
    dqOe_ff && patSel_ff |-> dqOut_ff == {DQ_W{dqOut_ff[0]}}
  ) else $error("pattern lanes differ");
  a_pattern_a_seq: assert property ( // R11
    @(posedge ref_clk) disable iff (!rst_n || !clkEn)
    $rose(dqOe_ff) && patSel_ff && patBits_ff == PATTERN_A_BITS
    |-> dqOut_ff[0] ##1 !dqOut_ff[0] ##1 dqOut_ff[0] ##1 !dqOut_ff[0]
  ) else $error("pattern A sequence wrong");
  a_readonly_ignored: assert property ( // R15
    @(posedge ref_clk) disable iff (!rst_n || !clkEn)
    mrwGo && !cfgHit && !resetGo |=> $stable(cfgRegs)
  ) else $error("read-only write changed a register");
  a_cfg_write: assert property ( // R14
    @(posedge ref_clk) disable iff (!rst_n || !clkEn)
    mrwGo && cfgHit |=> cfg_ff[$past(cfgIdx)] == $past(mrData)
  ) else $error("register write not stored");
  a_reset_defaults: assert property ( // R18
    @(posedge ref_clk) disable iff (!rst_n || !clkEn)
    resetGo |=> autoInitBusy_ff && arrayUndefined_ff && cfgRegs == {NUM_CFG{CFG_DEFAULT}}
  ) else $error("reset write did not restore defaults");
  a_cal_ignored: assert property ( // R23
    @(posedge ref_clk) disable iff (!rst_n || !clkEn)
    mrwGo && calHit && zqTiedSupply |=> !calBusy_ff && $stable(impAccuracy_ff)
  ) else $error("calibration ran with ball tied to supply");
  a_sensor_interval: assert property ( // R8
    @(posedge ref_clk) disable iff (!rst_n || !clkEn)
    sinceLoad_ff <= 32'(SENSOR_CYCLES)
  ) else $error("temperature status too old");
  a_exit_refresh: assert property ( // R9
    @(posedge ref_clk) disable iff (!rst_n || !clkEn)
    lowPowerExit |=> sensorTick ##1 tempStatus_ff == $past(sensorTemp)
  ) else $error("no refresh after low-power exit");
endmodule // lpmra_mode_reg
`default_nettype wire

// ### lpmra_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module lpmra_ctrl_model (
  input wire logic ref_clk,
  input wire logic cmdBusy,
  output logic csN,
  output logic [lpmra_pkg::CA_W-1:0] caRise,
  output logic [lpmra_pkg::CA_W-1:0] caFall
);
  import lpmra_pkg::*;
  initial
  begin
    csN = 1'b1;
    caRise = 10'h3ff;
    caFall = 10'h3ff;
  end
  // Waits for a quiet device, then presents one command for one cycle
  task automatic send(input logic isRead, input logic [7:0] addr, input logic [7:0] data,
    output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 300 && !ok; n++)
    begin
      @(posedge ref_clk);
      #10;
      ok = (cmdBusy === 1'b0);
    end
    if (ok)
    begin
      csN = 1'b0;
      caRise = {addr[7:2], isRead ? MRR_OPCODE : MRW_OPCODE};
      caFall = {data, addr[1:0]};
      @(posedge ref_clk);
      #10;
      csN = 1'b1;
      caRise = ~caRise;
      caFall = ~caFall;
    end
  endtask
endmodule // lpmra_ctrl_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import lpmra_pkg::*;
  logic ref_clk, rst_n, clkEn, csN, zqTiedSupply, lowPowerExit;
  logic [CA_W-1:0] caRise, caFall;
  logic [TEMP_W-1:0] sensorTemp, tempStatus;
  logic [15:0] dqOut;
  logic [1:0] dqsOut;
  logic dqOe, cmdBusy, calBusy, autoInitBusy, arrayUndefined, impAccuracy;
  logic [23:0] cfgRegs;
  logic [15:0] expQ[$];
  logic [7:0] d [3];
  logic [7:0] calCode [4];
  logic calExp [4];
  int errors = 0;
  int compares = 0;
  int seed = 65148;
  int beat = 0;
  int i;

  lpmra_mode_reg #(.SENSOR_CYCLES(50)) lpmra_mode_reg_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .clkEn(clkEn), .csN(csN), .caRise(caRise), .caFall(caFall), .zqTiedSupply(zqTiedSupply),
    .sensorTemp(sensorTemp), .lowPowerExit(lowPowerExit), .dqOut(dqOut), .dqOe(dqOe),
    .dqsOut(dqsOut), .cmdBusy(cmdBusy), .calBusy(calBusy), .autoInitBusy(autoInitBusy),
    .arrayUndefined(arrayUndefined), .impAccuracy(impAccuracy), .tempStatus(tempStatus),
    .cfgRegs(cfgRegs));
  lpmra_ctrl_model lpmra_ctrl_model_inst (.ref_clk(ref_clk), .cmdBusy(cmdBusy), .csN(csN),
    .caRise(caRise), .caFall(caFall));

  initial
  begin
    ref_clk = 1'b0;
  end
  always #50 ref_clk = ~ref_clk;

  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input logic isRead, input logic [7:0] addr, input logic [7:0] data);
    bit ok;
    lpmra_ctrl_model_inst.send(isRead, addr, data, ok);
    if (!ok)
    begin
      errors++;
      wrap_up();
    end
  endtask

  task automatic read_exp(input logic [7:0] addr, input logic [15:0] b0, input logic [15:0] b1,
    input logic [15:0] b2, input logic [15:0] b3);
    expQ.push_back(b0);
    expQ.push_back(b1);
    expQ.push_back(b2);
    expQ.push_back(b3);
    cmd(1'b1, addr, 8'h00);
  endtask

  // Bounded wait until every expected beat was seen and the device is quiet
  task automatic settle();
    int n;
    for (n = 0; n < 300 && (expQ.size() != 0 || cmdBusy !== 1'b0); n++)
      @(posedge ref_clk);
    #10;
    if (expQ.size() != 0 || cmdBusy !== 1'b0)
    begin
      errors++;
      wrap_up();
    end
  endtask

  // Watches the data bus and takes the oldest expected beat
  always @(negedge ref_clk)
  begin
    if (dqOe === 1'b1)
    begin
      if (expQ.size() == 0)
        check("dq beat count", 24'h1, 24'h0);
      else
        check("dqOut", {8'h00, expQ.pop_front()}, {8'h00, dqOut});
      check("dqsOut", (beat % 2 == 0) ? 24'h3 : 24'h0, {22'h0, dqsOut});
      beat = (beat + 1) % 4;
    end
  end

  initial
  begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    zqTiedSupply = 1'b0;
    sensorTemp = 3'h0;
    lowPowerExit = 1'b0;
    calCode = '{CAL_INIT_CODE, CAL_RESET_CODE, CAL_LONG_CODE, CAL_SHORT_CODE};
    calExp = '{1'b1, 1'b0, 1'b1, 1'b1};
    repeat (4) @(posedge ref_clk);
    #10;
    rst_n = 1'b1;
    // Back-to-back writes with random data, then read-back and an unmapped read
    for (i = 0; i < 3; i++)
    begin
      d[i] = 8'($random(seed));
      cmd(1'b0, CFG_BASE_ADDR + 8'(i), d[i]);
    end
    settle();
    check("cfgRegs", {d[2], d[1], d[0]}, cfgRegs);
    for (i = 0; i < 3; i++)
      read_exp(CFG_BASE_ADDR + 8'(i), {8'h00, d[i]}, 16'h0, 16'h0, 16'h0);
    read_exp(8'h3e, 16'h0, 16'h0, 16'h0, 16'h0);
    settle();
    $display("test config access done");
    // Writes aimed at read-only places
    cmd(1'b0, TEMP_STATUS_ADDR, 8'hff);
    cmd(1'b0, CALIB_PATTERN_A_ADDR, 8'h5a);
    settle();
    check("cfgRegs read-only", {d[2], d[1], d[0]}, cfgRegs);
    // Frozen clock enable lets a presented write pass untaken
    clkEn = 1'b0;
    cmd(1'b0, CFG_BASE_ADDR, ~d[0]);
    check("cmdBusy frozen", 24'h0, {23'h0, cmdBusy});
    check("cfgRegs frozen", {d[2], d[1], d[0]}, cfgRegs);
    clkEn = 1'b1;
    settle();
    check("cfgRegs after freeze", {d[2], d[1], d[0]}, cfgRegs);
    $display("test clock enable freeze done");
    // Calibration pattern reads
    read_exp(CALIB_PATTERN_A_ADDR, 16'hffff, 16'h0, 16'hffff, 16'h0);
    read_exp(CALIB_PATTERN_B_ADDR, 16'h0, 16'h0, 16'hffff, 16'hffff);
    settle();
    $display("test calibration patterns done");
    // Impedance calibration without and with a resistor
    zqTiedSupply = 1'b1;
    cmd(1'b0, IMPEDANCE_CAL_ADDR, CAL_INIT_CODE);
    check("calBusy tied", 24'h0, {23'h0, calBusy});
    settle();
    check("impAccuracy tied", 24'h0, {23'h0, impAccuracy});
    zqTiedSupply = 1'b0;
    for (i = 0; i < 4; i++)
    begin
      cmd(1'b0, IMPEDANCE_CAL_ADDR, calCode[i]);
      check("calBusy", 24'h1, {23'h0, calBusy});
      settle();
      check("impAccuracy", {23'h0, calExp[i]}, {23'h0, impAccuracy});
    end
    // Unknown calibration code acts as a plain write
    cmd(1'b0, IMPEDANCE_CAL_ADDR, 8'h7f);
    check("calBusy unknown code", 24'h0, {23'h0, calBusy});
    settle();
    check("impAccuracy unknown code", 24'h1, {23'h0, impAccuracy});
    $display("test impedance calibration done");
    // Temperature status, periodic and after low-power exit
    sensorTemp = 3'($random(seed)) | 3'h4;
    repeat (60) @(posedge ref_clk);
    #10;
    check("tempStatus", {21'h0, sensorTemp}, {21'h0, tempStatus});
    read_exp(TEMP_STATUS_ADDR, {13'h0, sensorTemp}, 16'h0, 16'h0, 16'h0);
    settle();
    sensorTemp = ~sensorTemp;
    lowPowerExit = 1'b1;
    @(posedge ref_clk);
    #10;
    lowPowerExit = 1'b0;
    repeat (2) @(posedge ref_clk);
    #10;
    check("tempStatus exit", {21'h0, sensorTemp}, {21'h0, tempStatus});
    $display("test temperature status done");
    // Reset by register write
    cmd(1'b0, RESET_ADDR, 8'h00);
    check("autoInitBusy", 24'h1, {23'h0, autoInitBusy});
    check("cfgRegs default", {3{CFG_DEFAULT}}, cfgRegs);
    settle();
    check("arrayUndefined", 24'h1, {23'h0, arrayUndefined});
    $display("test reset write done");
    // Hardware reset in mid-run clears the sticky array flag
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #10;
    rst_n = 1'b1;
    @(posedge ref_clk);
    #10;
    check("arrayUndefined after rst_n", 24'h0, {23'h0, arrayUndefined});
    check("cfgRegs after rst_n", 24'h0, cfgRegs);
    read_exp(CFG_BASE_ADDR, 16'h0, 16'h0, 16'h0, 16'h0);
    settle();
    $display("test hardware reset done");
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
